// ### inc/secsup_pkg.sv
package secsup_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_STATUS_CLR = 12'h008;
  localparam logic [11:0] OFS_IRQ_EN = 12'h00C;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h010;
  localparam logic [11:0] OFS_IRQ_CLR = 12'h014;
  localparam logic [11:0] OFS_CTRL = 12'h018;
  localparam logic [11:0] OFS_PIN_PROT = 12'h01C;
  localparam logic [11:0] OFS_NIRQ_DIS = 12'h088;
  localparam logic [11:0] OFS_NIRQ_MASK = 12'h08C;
  localparam logic [11:0] OFS_WAKE_PROT = 12'h090;
  // ----------------------------------------------------------------
  // Status field positions
  // ----------------------------------------------------------------
  localparam int BIT_DONE = 0;
  localparam int BIT_ERASING = 1;
  localparam int BIT_BACKUP = 2;
  localparam int BIT_WAKE = 3;
  localparam int BIT_AUTO = 6;
  localparam int BIT_SCRAMBLE = 7;
  // Control register: bit 0 starts an erase
  localparam int BIT_START = 0;
  // Interrupt event positions
  localparam int EV_DONE = 0;
  localparam int EV_WAKE = 1;
  localparam int EV_ERR = 2;
  localparam int NUM_EV = 3;
  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_NIRQ_MASK = 32'h0000_0000;
  localparam logic [31:0] RST_WAKE_PROT = 32'h0000_0000;
  localparam logic [31:0] RST_PIN_PROT = 32'h0000_0000;
  localparam int ERASE_CYCLES = 16;
  localparam int TIMING_HALF_DIV = 4;
endpackage

// ### verilog/half_tick_gen.sv
`timescale 1ns/1ns
// Makes one-cycle pulses at each half period of the internal timing clock
module half_tick_gen #(
  parameter int HALF_DIV = 4
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  output logic half_tick_o
);
  logic [7:0] cnt_q;

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      cnt_q <= 8'h00;
      half_tick_o <= 1'b0;
    end
    else if (cnt_q == 8'(HALF_DIV - 1))
    begin
      cnt_q <= 8'h00;
      half_tick_o <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 8'h01;
      half_tick_o <= 1'b0;
    end
  end
endmodule

// ### verilog/security_supervisor.sv
`timescale 1ns/1ns
// Status and protection register bank of the security supervisor
module security_supervisor #(
  parameter int ERASE_CYCLES = secsup_pkg::ERASE_CYCLES,
  parameter int HALF_DIV = secsup_pkg::TIMING_HALF_DIV
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic backup_nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic tamper_erase_i,
  input wire logic backup_mode_i,
  input wire logic soft_wake_i,
  input wire logic auto_standby_i,
  input wire logic scrambling_i,
  input wire logic mem_req_i,
  output logic mem_grant_o,
  output logic secure_memory_irq_o,
  output logic irq_o,
  output logic [31:0] pin_prot_active_o
);
  // Erase sequencer states; each step changes one bit except ST_WAIT_HALF back to ST_IDLE
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WIPE = 2'b01,
    ST_WAIT_HALF = 2'b11
  } erase_state_t;

  // Registered state, plus the combinational event set strobes
  erase_state_t state_q;
  logic [15:0] wipe_cnt_q;
  logic erase_done_q;
  logic soft_wake_flag_q;
  logic erase_pend_q;
  logic [31:0] nirq_mask_q;
  logic [31:0] wake_prot_q;
  logic [31:0] pin_prot_q;
  logic pin_armed_q;
  logic [secsup_pkg::NUM_EV-1:0] ev_stat_q;
  logic [secsup_pkg::NUM_EV-1:0] ev_en_q;
  logic [secsup_pkg::NUM_EV-1:0] ev_set;
  // Strobes and decodes
  logic half_tick;
  logic wr_en;
  logic rd_en;
  logic done_set;
  logic done_clr;
  logic wake_clr;
  logic start_req;
  logic erasing;

  // Returns one when the address is one of the mapped words
  function automatic logic addr_mapped(input logic [11:0] a);
    case (a)
      secsup_pkg::OFS_STATUS,
      secsup_pkg::OFS_STATUS_CLR,
      secsup_pkg::OFS_IRQ_EN,
      secsup_pkg::OFS_IRQ_STAT,
      secsup_pkg::OFS_IRQ_CLR,
      secsup_pkg::OFS_CTRL,
      secsup_pkg::OFS_PIN_PROT,
      secsup_pkg::OFS_NIRQ_DIS,
      secsup_pkg::OFS_NIRQ_MASK,
      secsup_pkg::OFS_WAKE_PROT: addr_mapped = 1'b1;
      default: addr_mapped = 1'b0;
    endcase
  endfunction

  // Write decode shared by all write effects
  function automatic logic wr_hit(input logic en, input logic [11:0] a,
                                  input logic [11:0] ofs);
    wr_hit = en && (a == ofs);
  endfunction

  // ----------------------------------------------------------------
  // Timing and bus strobes
  // ----------------------------------------------------------------
  half_tick_gen #(
    .HALF_DIV(HALF_DIV)
  ) u_half_tick (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .half_tick_o(half_tick)
  );

  // Access phase always completes in its first cycle
  assign wr_en = psel_i && penable_i && pwrite_i && addr_mapped(paddr_i);
  assign rd_en = psel_i && !penable_i && !pwrite_i;
  assign erasing = (state_q == ST_WIPE);
  assign start_req = tamper_erase_i
    || (wr_hit(wr_en, paddr_i, secsup_pkg::OFS_CTRL) && pwdata_i[secsup_pkg::BIT_START]);
  assign done_set = (state_q == ST_WAIT_HALF) && half_tick;
  // Only a written one clears; zero writes leave the flag
  assign done_clr = (wr_hit(wr_en, paddr_i, secsup_pkg::OFS_STATUS)
    || wr_hit(wr_en, paddr_i, secsup_pkg::OFS_STATUS_CLR)) && pwdata_i[secsup_pkg::BIT_DONE];
  assign wake_clr = wr_hit(wr_en, paddr_i, secsup_pkg::OFS_STATUS_CLR)
    && pwdata_i[secsup_pkg::BIT_WAKE];

  // ----------------------------------------------------------------
  // Erase state machine
  // ----------------------------------------------------------------
  // Sequencer; the done flag plays no part in starting
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      state_q <= ST_IDLE;
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          // A queued start is taken as soon as the machine is idle
          if (start_req || erase_pend_q)
            state_q <= ST_WIPE;
        end
        ST_WIPE:
        begin
          // Leaving on a tick puts done exactly half a period later
          if ((wipe_cnt_q == 16'(ERASE_CYCLES - 1)) && half_tick)
            state_q <= ST_WAIT_HALF;
        end
        ST_WAIT_HALF:
        begin
          // The tick that ends this wait also raises done
          if (half_tick)
            state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Wipe length; the wipe may run up to one tick spacing past its count
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      wipe_cnt_q <= 16'h0000;
    else if (state_q != ST_WIPE)
      wipe_cnt_q <= 16'h0000;
    else if (wipe_cnt_q != 16'(ERASE_CYCLES - 1))
      wipe_cnt_q <= wipe_cnt_q + 16'h0001;
  end

  // A start during the final wait is queued so it is never dropped;
  // a start seen mid-wipe is already served by the running erase
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      erase_pend_q <= 1'b0;
    else if ((state_q == ST_WAIT_HALF) && start_req)
      erase_pend_q <= 1'b1;
    else if (state_q == ST_IDLE)
      erase_pend_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Sticky status flags
  // ----------------------------------------------------------------
  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      erase_done_q <= 1'b0;
    else if (done_set)
      erase_done_q <= 1'b1;
    else if (done_clr)
      erase_done_q <= 1'b0;
  end

  // Wake-up flag; a wake-up in the clearing cycle keeps it set
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      soft_wake_flag_q <= 1'b0;
    else if (soft_wake_i)
      soft_wake_flag_q <= 1'b1;
    else if (wake_clr)
      soft_wake_flag_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Protection registers
  // ----------------------------------------------------------------
  // Disable register is write-only and clears mask bits
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      nirq_mask_q <= secsup_pkg::RST_NIRQ_MASK;
    else if (wr_hit(wr_en, paddr_i, secsup_pkg::OFS_NIRQ_DIS))
      nirq_mask_q <= nirq_mask_q & ~pwdata_i;
  end

  // Wake-up protection word is plain read/write
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      wake_prot_q <= secsup_pkg::RST_WAKE_PROT;
    else if (wr_hit(wr_en, paddr_i, secsup_pkg::OFS_WAKE_PROT))
      wake_prot_q <= pwdata_i;
  end

  // Backup reset disarms every pin until software enables it again
  always_ff @(posedge clk_i)
  begin
    if (!backup_nrst_i)
    begin
      pin_prot_q <= secsup_pkg::RST_PIN_PROT;
      pin_armed_q <= 1'b0;
    end
    else if (wr_hit(wr_en, paddr_i, secsup_pkg::OFS_PIN_PROT))
    begin
      pin_prot_q <= pwdata_i;
      pin_armed_q <= 1'b1;
    end
  end

  // Protections reach the pins only once armed since the last backup reset
  always_ff @(posedge clk_i)
  begin
    if (!backup_nrst_i)
      pin_prot_active_o <= 32'h0000_0000;
    else
      pin_prot_active_o <= pin_armed_q ? pin_prot_q : 32'h0000_0000;
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  // Events: erase done, software wake-up, access attempted while wiping
  assign ev_set[secsup_pkg::EV_DONE] = done_set;
  assign ev_set[secsup_pkg::EV_WAKE] = soft_wake_i;
  assign ev_set[secsup_pkg::EV_ERR] = erasing && mem_req_i;

  // One sticky bit per event; a set in the same cycle beats a clear
  genvar gi;
  generate
    for (gi = 0; gi < secsup_pkg::NUM_EV; gi++)
    begin : g_ev
      always_ff @(posedge clk_i)
      begin
        if (!nrst_i)
          ev_stat_q[gi] <= 1'b0;
        else if (ev_set[gi])
          ev_stat_q[gi] <= 1'b1;
        else if (wr_hit(wr_en, paddr_i, secsup_pkg::OFS_IRQ_CLR) && pwdata_i[gi])
          ev_stat_q[gi] <= 1'b0;
      end
    end
  endgenerate

  // Interrupt enables, same layout as the event bits
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      ev_en_q <= '0;
    else if (wr_hit(wr_en, paddr_i, secsup_pkg::OFS_IRQ_EN))
      ev_en_q <= pwdata_i[secsup_pkg::NUM_EV-1:0];
  end

  // Level interrupt, one cycle behind the enabled event bits
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(ev_stat_q & ev_en_q);
  end

  // Secure-memory line mirrors the done flag; only clearing the flag drops it
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      secure_memory_irq_o <= 1'b0;
    else
      secure_memory_irq_o <= erase_done_q;
  end

  // ----------------------------------------------------------------
  // Secure memory access gate
  // ----------------------------------------------------------------
  // Refused from the cycle a start is seen and while a queued start waits,
  // so no access slips in ahead of the wipe
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      mem_grant_o <= 1'b0;
    else
      mem_grant_o <= mem_req_i && !erasing && !start_req && !erase_pend_q;
  end

  // ----------------------------------------------------------------
  // APB read path
  // ----------------------------------------------------------------
  // Read data is latched in setup so it is ready in the access phase
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      prdata_o <= 32'h0000_0000;
    else if (rd_en)
    begin
      case (paddr_i)
        secsup_pkg::OFS_STATUS:
        begin
          prdata_o <= 32'h0000_0000;
          prdata_o[secsup_pkg::BIT_DONE] <= erase_done_q;
          prdata_o[secsup_pkg::BIT_ERASING] <= erasing;
          prdata_o[secsup_pkg::BIT_BACKUP] <= backup_mode_i;
          prdata_o[secsup_pkg::BIT_WAKE] <= soft_wake_flag_q;
          prdata_o[secsup_pkg::BIT_AUTO] <= auto_standby_i;
          prdata_o[secsup_pkg::BIT_SCRAMBLE] <= scrambling_i;
        end
        secsup_pkg::OFS_IRQ_EN: prdata_o <= 32'(ev_en_q);
        secsup_pkg::OFS_IRQ_STAT: prdata_o <= 32'(ev_stat_q);
        secsup_pkg::OFS_PIN_PROT: prdata_o <= pin_prot_q;
        secsup_pkg::OFS_NIRQ_MASK: prdata_o <= nirq_mask_q;
        secsup_pkg::OFS_WAKE_PROT: prdata_o <= wake_prot_q;
        default: prdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // Zero-wait answer; unmapped addresses report an error
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
    begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
    else
    begin
      pready_o <= psel_i && !penable_i;
      pslverr_o <= psel_i && !penable_i && !addr_mapped(paddr_i);
    end
  end
endmodule

// ### verification/security_supervisor_checker.sv
`timescale 1ns/1ns
module security_supervisor_checker #(
  parameter int ERASE_CYCLES = 16,
  parameter int HALF_DIV = 4
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic backup_nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic tamper_erase_i,
  input wire logic mem_req_i,
  input wire logic mem_grant_o,
  input wire logic secure_memory_irq_o,
  input wire logic [31:0] pin_prot_active_o
);
  // ------------------------------------------------------------
  // Port relations
  // ------------------------------------------------------------
  // Done may come late by a full internal period plus register stages
  localparam int DONE_MIN = ERASE_CYCLES + 1;
  localparam int DONE_MAX = ERASE_CYCLES + 2 * HALF_DIV + 6;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // Bus answers one cycle after setup and only in the access phase
  bus_answer_a: assert property (psel_i && !penable_i |=> pready_o)
    else $error("pready missing after setup");
  ready_access_a: assert property (pready_o |-> psel_i && penable_i)
    else $error("pready outside access phase");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("pready longer than one cycle");
  error_read_a: assert property (pslverr_o && !pwrite_i |-> pready_o && prdata_o == 32'h0)
    else $error("refused read not zero");
  grant_cause_a: assert property (mem_grant_o |-> $past(mem_req_i))
    else $error("grant without request");
  erase_block_a: assert property ($rose(tamper_erase_i) |-> ##3 !mem_grant_o [*8])
    else $error("memory granted while erasing");
  done_irq_a: assert property ($rose(tamper_erase_i) |-> ##[DONE_MIN:DONE_MAX] secure_memory_irq_o)
    else $error("erase done interrupt missing");
  irq_clear_a: assert property ($fell(secure_memory_irq_o) |-> $past(pwrite_i && penable_i, 2))
    else $error("interrupt dropped without clear");
  pin_reset_a: assert property (!backup_nrst_i |=> pin_prot_active_o == 32'h0)
    else $error("pin protection active after backup reset");
endmodule

bind security_supervisor security_supervisor_checker #(.ERASE_CYCLES(ERASE_CYCLES),
  .HALF_DIV(HALF_DIV)) chk_u (.clk_i, .nrst_i, .backup_nrst_i, .psel_i, .penable_i,
  .pwrite_i, .prdata_o, .pready_o, .pslverr_o, .tamper_erase_i, .mem_req_i, .mem_grant_o,
  .secure_memory_irq_o, .pin_prot_active_o);

// ### verification/security_supervisor_tb.sv
`timescale 1ns/1ns
module security_supervisor_tb;
  // ------------------------------------------------------------
  // Bench signals
  // ------------------------------------------------------------
  logic clk_i, nrst_i, backup_nrst_i, psel_i, penable_i, pwrite_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, pin_prot_active_o, v;
  logic pready_o, pslverr_o, tamper_erase_i, backup_mode_i, soft_wake_i, auto_standby_i;
  logic scrambling_i, mem_req_i, mem_grant_o, secure_memory_irq_o, irq_o;
  logic [32:0] exp_q[$];
  int err_total, n_compared;
  security_supervisor dut_u (.clk_i, .nrst_i, .backup_nrst_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .tamper_erase_i,
    .backup_mode_i, .soft_wake_i, .auto_standby_i, .scrambling_i, .mem_req_i, .mem_grant_o,
    .secure_memory_irq_o, .irq_o, .pin_prot_active_o);
  // Free running 25 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task automatic check(input logic [32:0] seen, input logic [32:0] want, input string what);
    n_compared++;
    if (seen !== want)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // One APB transfer; only the watchdog ends a wait on a dead slave
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do
      @(posedge clk_i);
    while (pready_o !== 1'b1);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] want);
    exp_q.push_back(want);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic settle();
    repeat (2) @(posedge clk_i);
  endtask
  task automatic erase();
    @(posedge clk_i);
    tamper_erase_i <= 1'b1;
    @(posedge clk_i);
    tamper_erase_i <= 1'b0;
  endtask
  // Read monitor: each completed read is matched against the oldest note
  always @(posedge clk_i)
    if (psel_i && penable_i && pready_o && !pwrite_i)
      check({pslverr_o, prdata_o}, exp_q.pop_front(), "read");
  // Watchdog sized well above the expected few hundred cycles
  initial
  begin
    #400000;
    err_total++;
    finish_test();
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    {psel_i, penable_i, pwrite_i, tamper_erase_i, backup_mode_i, soft_wake_i} = '0;
    {auto_standby_i, scrambling_i, mem_req_i, nrst_i, backup_nrst_i} = '0;
    paddr_i = 12'h000;
    pwdata_i = 32'h0;
    err_total = 0;
    n_compared = 0;
    void'($urandom(32'hE224));
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'b1;
    backup_nrst_i <= 1'b1;
    check(pin_prot_active_o, 33'h0, "pins idle");
    rd(secsup_pkg::OFS_NIRQ_MASK, {1'b0, secsup_pkg::RST_NIRQ_MASK});
    rd(secsup_pkg::OFS_WAKE_PROT, {1'b0, secsup_pkg::RST_WAKE_PROT});
    rd(12'h0F0, 33'h1_0000_0000);
    v = $urandom();
    apb(1'b1, secsup_pkg::OFS_WAKE_PROT, v);
    rd(secsup_pkg::OFS_WAKE_PROT, {1'b0, v});
    apb(1'b1, secsup_pkg::OFS_NIRQ_MASK, v);
    apb(1'b1, secsup_pkg::OFS_NIRQ_DIS, v);
    rd(secsup_pkg::OFS_NIRQ_MASK, 33'h0);
    // Mirrored mode levels land in bits 2, 6 and 7
    repeat (4)
    begin
      v = $urandom();
      backup_mode_i <= v[0];
      auto_standby_i <= v[1];
      scrambling_i <= v[2];
      rd(secsup_pkg::OFS_STATUS, {25'h0, v[2], v[1], 3'h0, v[0], 2'h0});
    end
    {backup_mode_i, auto_standby_i, scrambling_i} <= 3'h0;
    soft_wake_i <= 1'b1;
    @(posedge clk_i);
    soft_wake_i <= 1'b0;
    rd(secsup_pkg::OFS_STATUS, 33'h8);
    rd(secsup_pkg::OFS_IRQ_STAT, 33'h2);
    apb(1'b1, secsup_pkg::OFS_IRQ_EN, 32'h2);
    settle();
    check(irq_o, 33'h1, "irq enabled");
    apb(1'b1, secsup_pkg::OFS_IRQ_EN, 32'h0);
    settle();
    check(irq_o, 33'h0, "irq masked");
    apb(1'b1, secsup_pkg::OFS_STATUS_CLR, 32'h8);
    apb(1'b1, secsup_pkg::OFS_IRQ_CLR, 32'h7);
    rd(secsup_pkg::OFS_STATUS, 33'h0);
    rd(secsup_pkg::OFS_IRQ_STAT, 33'h0);
    // First erase, then a second one over an uncleared done flag
    mem_req_i <= 1'b1;
    erase();
    rd(secsup_pkg::OFS_STATUS, 33'h2);
    repeat (30) @(posedge clk_i);
    rd(secsup_pkg::OFS_STATUS, 33'h1);
    check(secure_memory_irq_o, 33'h1, "secure irq");
    apb(1'b1, secsup_pkg::OFS_STATUS, 32'hFFFF_FFFE);
    rd(secsup_pkg::OFS_STATUS, 33'h1);
    erase();
    rd(secsup_pkg::OFS_STATUS, 33'h3);
    repeat (30) @(posedge clk_i);
    rd(secsup_pkg::OFS_STATUS, 33'h1);
    check(mem_grant_o, 33'h1, "grant after erase");
    apb(1'b1, secsup_pkg::OFS_STATUS, 32'h1);
    rd(secsup_pkg::OFS_STATUS, 33'h0);
    settle();
    check(secure_memory_irq_o, 33'h0, "secure irq cleared");
    // Software-started erase, done cleared through the clear word
    apb(1'b1, secsup_pkg::OFS_IRQ_CLR, 32'h7);
    apb(1'b1, secsup_pkg::OFS_IRQ_EN, 32'h1);
    apb(1'b1, secsup_pkg::OFS_CTRL, 32'h1);
    rd(secsup_pkg::OFS_STATUS, 33'h2);
    check(mem_grant_o, 33'h0, "grant while erasing");
    check(irq_o, 33'h0, "irq before done");
    repeat (30) @(posedge clk_i);
    check(irq_o, 33'h1, "irq on done");
    rd(secsup_pkg::OFS_IRQ_STAT, 33'h5);
    apb(1'b1, secsup_pkg::OFS_STATUS_CLR, 32'h1);
    rd(secsup_pkg::OFS_STATUS, 33'h0);
    apb(1'b1, secsup_pkg::OFS_IRQ_EN, 32'h0);
    // Pin protections follow the register until a backup reset
    v = $urandom();
    apb(1'b1, secsup_pkg::OFS_PIN_PROT, v);
    settle();
    check(pin_prot_active_o, {1'b0, v}, "pins armed");
    backup_nrst_i <= 1'b0;
    @(posedge clk_i);
    backup_nrst_i <= 1'b1;
    settle();
    check(pin_prot_active_o, 33'h0, "pins disarmed");
    rd(secsup_pkg::OFS_PIN_PROT, {1'b0, secsup_pkg::RST_PIN_PROT});
    settle();
    check(exp_q.size(), 33'h0, "reads answered");
    finish_test();
  end
endmodule
